// file: common/pswitch_pkg.sv
// constants shared by the fault-reporting and temperature-output logic
package pswitch_pkg;
	// -------------------------------------------------------------
	// clock and timing
	// -------------------------------------------------------------
	localparam int CLK_HZ           = 40000000;
	localparam int CLK_NS           = 25;
	localparam int PWM_FREQ_HZ      = 9000;
	localparam int PWM_PERIOD_CYC   = CLK_HZ / PWM_FREQ_HZ;
	localparam int PWM_MIN_HIGH_NS  = 30;
	localparam int PWM_MIN_HIGH_CYC = (PWM_MIN_HIGH_NS + CLK_NS - 1) / CLK_NS;
	localparam int STRAP_NS         = 200;
	localparam int STRAP_CYC        = (STRAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int DRIVE_STRENGTH_PIN_FILT_NS     = 50000;
	localparam int DRIVE_STRENGTH_PIN_FILT_CYC    = (DRIVE_STRENGTH_PIN_FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int SC_CLR_NS        = 1000;
	localparam int SC_CLR_CYC       = (SC_CLR_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W            = 16;

	// -------------------------------------------------------------
	// temperature encoding: deg = 162.3 * duty + 20.1 (x10 fixed point)
	// -------------------------------------------------------------
	localparam int TEMP_W        = 8;
	localparam int TEMP_GAIN_X10 = 1623;
	localparam int TEMP_OFS_X10  = 201;
	localparam int TEMP_UNIT_X10 = 10;

	// -------------------------------------------------------------
	// drive-strength codes
	// -------------------------------------------------------------
	localparam int             SLEW_W        = 4;
	localparam logic [SLEW_W-1:0] SLEW_CODE_150 = 4'h0; // pin tied to ground
	localparam logic [SLEW_W-1:0] SLEW_CODE_100 = 4'h8; // pin tied to aux 5v rail

	// -------------------------------------------------------------
	// synchroniser bit positions
	// -------------------------------------------------------------
	localparam int SY_CMD   = 0;
	localparam int SY_UVLO  = 1;
	localparam int SY_OC    = 2;
	localparam int SY_SC    = 3;
	localparam int SY_GTRIP = 4;
	localparam int SY_GCLR  = 5;
	localparam int SY_DTRIP = 6;
	localparam int SY_DCLR  = 7;
	localparam int SY_HIZ   = 8;
	localparam int SY_TIE5  = 9;
	localparam int SY_Q1    = 10;
	localparam int SY_Q3    = 11;
	localparam int SY_OCPIN = 12;
	localparam int SY_CODE  = 13;
	localparam int SY_TEMP  = SY_CODE + SLEW_W;
	localparam int SY_W     = SY_TEMP + TEMP_W;

	typedef enum logic [0:0] {
		ST_STRAP = 1'b0,
		ST_RUN   = 1'b1
	} run_state_t;
endpackage

// file: common/temp_link_if.sv
// link between the fault core and the temperature pwm generator
`timescale 1ns/1ps
interface temp_link_if import pswitch_pkg::*; ();
	logic [TEMP_W-1:0] temp;
	logic              ot;
	logic              pwm;
	modport src (output temp, output ot, input pwm);
	modport gen (input temp, input ot, output pwm);
endinterface

// file: rtl/temp_pwm_gen.sv
// temperature-encoded pwm generator
`timescale 1ns/1ps
module temp_pwm_gen
	import pswitch_pkg::*;
#(
	parameter int PERIOD = PWM_PERIOD_CYC
) (
	// clock and reset
	input wire logic   clk,
	input wire logic   rst_n,
	// temperature link
	temp_link_if.gen   lnk
);
	localparam int PW = $clog2(PERIOD + 1);

	logic [PW-1:0] cnt_r, cnt_nxt;
	logic [PW-1:0] high_r, high_nxt;
	logic          pwm_r, pwm_nxt;
	logic [PW-1:0] target;
	int            scaled;

	// -------------------------------------------------------------
	// duty from temperature, linear also above 150 degrees
	// -------------------------------------------------------------
	always_comb begin
		scaled = int'(lnk.temp) * TEMP_UNIT_X10 - TEMP_OFS_X10;
		if (scaled < 0)
			scaled = 0;
		scaled = (scaled * PERIOD) / TEMP_GAIN_X10;
		if (scaled < PWM_MIN_HIGH_CYC)
			scaled = PWM_MIN_HIGH_CYC;
		if (scaled > PERIOD - 1)
			scaled = PERIOD - 1; // keep one low cycle below the trip point
		target = PW'(scaled);
	end

	// -------------------------------------------------------------
	// period counter; duty reloads only at period start
	// -------------------------------------------------------------
	always_comb begin
		cnt_nxt  = (cnt_r == PW'(PERIOD - 1)) ? '0 : cnt_r + PW'(1);
		high_nxt = (cnt_r == PW'(PERIOD - 1)) ? target : high_r;
		pwm_nxt  = lnk.ot || (cnt_nxt < high_nxt);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r  <= PW'(PERIOD - 1); // wrap on the first edge so the first pulse is full width
			high_r <= PW'(PWM_MIN_HIGH_CYC);
			pwm_r  <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			high_r <= high_nxt;
			pwm_r  <= pwm_nxt;
		end
	end

	assign lnk.pwm = pwm_r;

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	a_pwm_min_high: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(pwm_r) |-> pwm_r [*2])
		else $error("temperature pulse shorter than minimum");
	a_pwm_ot_high: assert property (@(posedge clk) disable iff (!rst_n)
		lnk.ot |=> pwm_r)
		else $error("temperature output not high during overtemperature");
	a_pwm_reload: assert property (@(posedge clk) disable iff (!rst_n)
		(cnt_r != PW'(PERIOD - 1)) |=> $stable(high_r))
		else $error("duty changed inside a pwm period");
	c_pwm_ot: cover property (@(posedge clk) disable iff (!rst_n) $rose(lnk.ot));
endmodule

// file: rtl/power_switch_fault_and_temp_report.sv
// fault reporting, drive-strength decode and temperature output of a power switch driver
// Notes on behaviour
// - monitored drive pin at high impedance: switch off, general fault low.
// - high impedance gone: fault released, switching resumes without reset.
// - overcurrent pin grounded at power-up selects single-output reporting.
// - two-output truth table for general and overcurrent outputs.
// - single-output mode: general fault low for any fault.
// - ground tie 150V/ns, 5V tie 100V/ns, resistor gives intermediate slew.
// - 5V tie checked once at power-up; if found, pin monitoring stops.
// - otherwise monitor drive pin continuously through heavy filtering.
// - temperature pwm about 9kHz, value refreshed once per period.
// - duty about 3% to 80% over 25 to 150 degrees.
// - temperature high pulse never shorter than about 30ns.
// - above 150 degrees duty keeps rising linearly until trip.
// - overtemperature holds temperature output high until cooled with hysteresis.
// - ideal-diode: off on first-quadrant current, on on third-quadrant current.
// - overcurrent indication cleared when switch command goes low.
// - short circuit latches off until command low for set time.
// - general fault held while either sensor shut down, until both cleared.
`timescale 1ns/1ps
module power_switch_fault_and_temp_report
	import pswitch_pkg::*;
#(
	parameter int PWM_PERIOD    = PWM_PERIOD_CYC,
	parameter int SC_CLR_CYCLES = SC_CLR_CYC,
	parameter int FILT_CYCLES   = DRIVE_STRENGTH_PIN_FILT_CYC
) (
	// clock and reset
	input  wire logic              CLK,
	input  wire logic              RST_N,
	// switch command and sensed conditions
	input  wire logic              SWITCH_CMD,
	input  wire logic              UVLO,
	input  wire logic              OC_DETECT,
	input  wire logic              SC_DETECT,
	input  wire logic              GAN_OT_TRIP,
	input  wire logic              GAN_OT_CLEAR,
	input  wire logic              DRV_OT_TRIP,
	input  wire logic              DRV_OT_CLEAR,
	input  wire logic              Q1_CURRENT,
	input  wire logic              Q3_CURRENT,
	input  wire logic [TEMP_W-1:0] TEMP_DEG,
	// drive-strength pin sensing
	input  wire logic              DRIVE_PIN_HIZ,
	input  wire logic              DRIVE_PIN_AUX_5V,
	input  wire logic [SLEW_W-1:0] DRIVE_PIN_CODE,
	// outputs
	output logic                   GATE_ON,
	output logic [SLEW_W-1:0]      SLEW_SEL,
	output logic                   FAULT_N,
	output logic                   OVERCURRENT_FLAG_N_O,
	output logic                   OVERCURRENT_FLAG_N_OE,
	input  wire logic              OVERCURRENT_FLAG_N_I,
	output logic                   TEMP_PWM
);
	localparam int SCW = $clog2(SC_CLR_CYCLES + 1);
	localparam int FW  = $clog2(FILT_CYCLES + 1);

	// -------------------------------------------------------------
	// two-stage synchroniser for every pin input
	// -------------------------------------------------------------
	logic [SY_W-1:0] pins, sy1_r, sy2_r;
	assign pins = {TEMP_DEG, DRIVE_PIN_CODE, OVERCURRENT_FLAG_N_I, Q3_CURRENT, Q1_CURRENT,
		DRIVE_PIN_AUX_5V, DRIVE_PIN_HIZ, DRV_OT_CLEAR, DRV_OT_TRIP, GAN_OT_CLEAR,
		GAN_OT_TRIP, SC_DETECT, OC_DETECT, UVLO, SWITCH_CMD};

	// multi-bit codes change slowly, so a torn sample lasts at most a cycle
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sy1_r <= '0;
			sy2_r <= '0;
		end else begin
			sy1_r <= pins;
			sy2_r <= sy1_r;
		end
	end

	logic cmd, uvlo, oc_det, sc_det, g_trip, g_clr, d_trip, d_clr, hiz, q1, q3;
	assign cmd    = sy2_r[SY_CMD];
	assign uvlo   = sy2_r[SY_UVLO];
	assign oc_det = sy2_r[SY_OC];
	assign sc_det = sy2_r[SY_SC];
	assign g_trip = sy2_r[SY_GTRIP];
	assign g_clr  = sy2_r[SY_GCLR];
	assign d_trip = sy2_r[SY_DTRIP];
	assign d_clr  = sy2_r[SY_DCLR];
	assign hiz    = sy2_r[SY_HIZ];
	assign q1     = sy2_r[SY_Q1];
	assign q3     = sy2_r[SY_Q3];

	// -------------------------------------------------------------
	// start-up strap capture and fault state
	// -------------------------------------------------------------
	run_state_t              st_r, st_nxt;
	logic [CNT_W-1:0]        strap_cnt_r, strap_cnt_nxt;
	logic                    single_r, single_nxt;
	logic                    tie5_r, tie5_nxt;
	logic                    oc_r, oc_nxt;
	logic                    sc_r, sc_nxt;
	logic [SCW-1:0]          sc_cnt_r, sc_cnt_nxt;
	logic                    got_r, got_nxt;
	logic                    dot_r, dot_nxt;
	logic                    hiz_r, hiz_nxt;
	logic [SLEW_W-1:0]       slew_r, slew_nxt;
	logic [FW-1:0]           filt_cnt_r, filt_cnt_nxt;
	logic [SLEW_W-1:0]       code_seen_r, code_seen_nxt;
	logic                    hiz_seen_r, hiz_seen_nxt;
	logic                    gate_r, gate_nxt;
	logic                    fault_n_r, fault_n_nxt;
	logic                    ocn_r, ocn_nxt;
	logic                    oce_r, oce_nxt;
	logic                    gen_fault;

	always_comb begin
		st_nxt        = st_r;
		strap_cnt_nxt = strap_cnt_r;
		single_nxt    = single_r;
		tie5_nxt      = tie5_r;
		if (st_r == ST_STRAP) begin
			strap_cnt_nxt = strap_cnt_r + CNT_W'(1);
			if (strap_cnt_r == CNT_W'(STRAP_CYC)) begin
				st_nxt     = ST_RUN;
				single_nxt = !sy2_r[SY_OCPIN];
				tie5_nxt   = sy2_r[SY_TIE5];
			end
		end

		// overcurrent per cycle: command low wins over set and clears it
		oc_nxt = (oc_r && cmd) || (oc_det && cmd);

		// short circuit latch, released after command held low long enough
		// a fresh detection restarts the count, so low time before it is not credited
		if (cmd || sc_det)
			sc_cnt_nxt = '0;
		else if (sc_cnt_r == SCW'(SC_CLR_CYCLES))
			sc_cnt_nxt = sc_cnt_r;
		else
			sc_cnt_nxt = sc_cnt_r + SCW'(1);
		if (sc_det)
			sc_nxt = 1'b1;
		else if (sc_cnt_r == SCW'(SC_CLR_CYCLES))
			sc_nxt = 1'b0;
		else
			sc_nxt = sc_r;

		// each sensor keeps its own hysteresis; the fault holds until both are clear,
		// and a cooled driver lets diode behaviour resume while the switch is still hot
		got_nxt = g_trip || (got_r && !g_clr);
		dot_nxt = d_trip || (dot_r && !d_clr);

		// heavy filter on drive pin: accept only after a long stable spell
		code_seen_nxt = sy2_r[SY_CODE +: SLEW_W];
		hiz_seen_nxt  = hiz;
		if (code_seen_nxt != code_seen_r || hiz_seen_nxt != hiz_seen_r)
			filt_cnt_nxt = '0;
		else if (filt_cnt_r != FW'(FILT_CYCLES))
			filt_cnt_nxt = filt_cnt_r + FW'(1);
		else
			filt_cnt_nxt = filt_cnt_r;
		hiz_nxt  = hiz_r;
		slew_nxt = slew_r;
		if (st_r == ST_RUN && tie5_r) begin
			hiz_nxt  = 1'b0;
			slew_nxt = SLEW_CODE_100;
		end else if (st_r == ST_RUN && filt_cnt_r == FW'(FILT_CYCLES)) begin
			hiz_nxt = hiz_seen_r;
			if (!hiz_seen_r)
				slew_nxt = code_seen_r;
		end

		// general fault and overcurrent output encoding
		gen_fault = uvlo || got_r || dot_r || hiz_r || sc_r || (st_r == ST_STRAP);
		if (single_r) begin
			fault_n_nxt = !(gen_fault || oc_r);
			ocn_nxt     = 1'b1;
			oce_nxt     = 1'b0; // pin is strapped to ground, never fight it
		end else begin
			fault_n_nxt = !gen_fault;
			ocn_nxt     = !(oc_r || sc_r);
			oce_nxt     = (st_r == ST_RUN);
		end

		// gate: ideal-diode behaviour while only the switch sensor is hot
		if (st_r == ST_STRAP || uvlo || hiz_r || sc_r || dot_r)
			gate_nxt = 1'b0;
		else if (got_r)
			gate_nxt = q3 && !q1;
		else
			gate_nxt = cmd && !oc_r && !oc_det;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_r        <= ST_STRAP;
			strap_cnt_r <= '0;
			single_r    <= 1'b0;
			tie5_r      <= 1'b0;
			oc_r        <= 1'b0;
			sc_r        <= 1'b0;
			sc_cnt_r    <= '0;
			got_r       <= 1'b0;
			dot_r       <= 1'b0;
			hiz_r       <= 1'b0;
			slew_r      <= SLEW_CODE_150;
			filt_cnt_r  <= '0;
			code_seen_r <= SLEW_CODE_150;
			hiz_seen_r  <= 1'b0;
			gate_r      <= 1'b0;
			fault_n_r   <= 1'b0;
			ocn_r       <= 1'b1;
			oce_r       <= 1'b0;
		end else begin
			st_r        <= st_nxt;
			strap_cnt_r <= strap_cnt_nxt;
			single_r    <= single_nxt;
			tie5_r      <= tie5_nxt;
			oc_r        <= oc_nxt;
			sc_r        <= sc_nxt;
			sc_cnt_r    <= sc_cnt_nxt;
			got_r       <= got_nxt;
			dot_r       <= dot_nxt;
			hiz_r       <= hiz_nxt;
			slew_r      <= slew_nxt;
			filt_cnt_r  <= filt_cnt_nxt;
			code_seen_r <= code_seen_nxt;
			hiz_seen_r  <= hiz_seen_nxt;
			gate_r      <= gate_nxt;
			fault_n_r   <= fault_n_nxt;
			ocn_r       <= ocn_nxt;
			oce_r       <= oce_nxt;
		end
	end

	// -------------------------------------------------------------
	// temperature output
	// -------------------------------------------------------------
	temp_link_if tlink ();
	assign tlink.temp = sy2_r[SY_TEMP +: TEMP_W];
	assign tlink.ot   = got_r || dot_r;

	temp_pwm_gen #(.PERIOD(PWM_PERIOD)) temp_pwm_gen_i (
		.clk   (CLK),
		.rst_n (RST_N),
		.lnk   (tlink.gen)
	);

	assign GATE_ON               = gate_r;
	assign SLEW_SEL              = slew_r;
	assign FAULT_N               = fault_n_r;
	assign OVERCURRENT_FLAG_N_O  = ocn_r;
	assign OVERCURRENT_FLAG_N_OE = oce_r;
	assign TEMP_PWM              = tlink.pwm;

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	a_hiz_gate_off: assert property (hiz_r |=> !GATE_ON && !FAULT_N)
		else $error("gate on or fault released during high impedance");
	a_hiz_release: assert property ($fell(hiz_r) && !gen_fault && !oc_r |=> FAULT_N)
		else $error("fault not released after high impedance cleared");
	a_mode_held: assert property (st_r == ST_RUN |=> $stable(single_r))
		else $error("reporting mode changed after power-up");
	a_mode_strap: assert property (st_r == ST_STRAP && st_nxt == ST_RUN
		|=> single_r == !$past(sy2_r[SY_OCPIN]))
		else $error("reporting mode not taken from strap");
	a_two_oc_code: assert property (!single_r && oc_r && !sc_r && !gen_fault
		|=> FAULT_N && !OVERCURRENT_FLAG_N_O)
		else $error("two-output overcurrent code wrong");
	a_two_sc_code: assert property (!single_r && sc_r |=> !FAULT_N && !OVERCURRENT_FLAG_N_O)
		else $error("two-output short-circuit code wrong");
	a_single_oc: assert property (single_r && oc_r |=> !FAULT_N && !OVERCURRENT_FLAG_N_OE)
		else $error("single-output overcurrent not on general fault");
	a_tie5_slew: assert property (st_r == ST_RUN && tie5_r |=> SLEW_SEL == SLEW_CODE_100)
		else $error("aux rail tie did not select its slew");
	a_oc_clear: assert property (oc_r && !cmd |=> !oc_r)
		else $error("overcurrent kept after command low");
	a_sc_hold: assert property (sc_r && cmd |=> sc_r && !GATE_ON)
		else $error("short circuit released while command high");
	a_ot_fault: assert property ((got_r || dot_r) |=> !FAULT_N)
		else $error("fault released during overtemperature");
	a_idm_gate: assert property (st_r == ST_RUN && got_r && !dot_r && !uvlo && !hiz_r
		&& !sc_r && q1 |=> !GATE_ON)
		else $error("gate on with first-quadrant current in diode mode");

	c_single_mode: cover property (st_r == ST_RUN && single_r);
	c_sc_release: cover property ($fell(sc_r));
	c_hiz_seen: cover property ($rose(hiz_r));
	c_idm_on: cover property (got_r && GATE_ON);
endmodule

// file: sim/supply_ctrl_model.sv
// controller-side model: strap on the overcurrent pin and a pwm duty meter
`timescale 1ns/1ps
module supply_ctrl_model (
	// clock
	input  wire logic        clk,
	// pins seen by the controller
	input  wire logic        temp_pwm,
	input  wire logic        oc_o,
	input  wire logic        oc_oe,
	input  wire logic        strap_gnd,
	output logic             oc_pin,
	// duty meter results
	output logic [15:0]      hi_cnt,
	output logic [15:0]      per_cnt
);
	logic [15:0] hi_acc = 16'h0000;
	logic [15:0] per_acc = 16'h0000;
	logic        pwm_d = 1'b0;

	// --------------------------------------------------------------
	// pin level
	// --------------------------------------------------------------
	// undriven pin sits at the rail pull-up unless the strap grounds it
	assign oc_pin = oc_oe ? oc_o : !strap_gnd;

	// --------------------------------------------------------------
	// duty meter
	// --------------------------------------------------------------
	// high time and period between rising edges; a constant high gives no edge
	always @(posedge clk) begin
		pwm_d <= temp_pwm;
		if (temp_pwm && !pwm_d) begin
			hi_cnt  <= hi_acc;
			per_cnt <= per_acc;
			hi_acc  <= 16'h0001;
			per_acc <= 16'h0001;
		end else begin
			hi_acc  <= hi_acc + {15'h0000, temp_pwm};
			per_acc <= per_acc + 16'h0001;
		end
	end
endmodule

// file: sim/test_power_switch_fault_and_temp_report.sv
// self-checking bench for the fault-reporting and temperature-output block
`timescale 1ns/1ps
module test_power_switch_fault_and_temp_report;
	import pswitch_pkg::*;
	localparam int P = 100;

	// --------------------------------------------------------------
	// signals
	// --------------------------------------------------------------
	logic CLK = 0, RST_N = 0, SWITCH_CMD = 0, UVLO = 0, OC_DETECT = 0, SC_DETECT = 0;
	logic GAN_OT_TRIP = 0, GAN_OT_CLEAR = 1, DRV_OT_TRIP = 0, DRV_OT_CLEAR = 1;
	logic Q1_CURRENT = 0, Q3_CURRENT = 0, DRIVE_PIN_HIZ = 0, DRIVE_PIN_AUX_5V = 0;
	logic [TEMP_W-1:0] TEMP_DEG = 8'h19;
	logic [SLEW_W-1:0] DRIVE_PIN_CODE = 4'h0;
	logic [SLEW_W-1:0] SLEW_SEL;
	logic GATE_ON, FAULT_N, OC_O, OC_OE, TEMP_PWM, oc_pin, strap_gnd = 0;
	logic [15:0] hi_cnt, per_cnt, code;
	int failures = 0, compares = 0, cycles = 0, hi;
	integer seed = 32'h6c75cb0f;

	power_switch_fault_and_temp_report #(.PWM_PERIOD(P), .SC_CLR_CYCLES(4), .FILT_CYCLES(8))
	power_switch_fault_and_temp_report_i (
		.CLK(CLK), .RST_N(RST_N), .SWITCH_CMD(SWITCH_CMD), .UVLO(UVLO),
		.OC_DETECT(OC_DETECT), .SC_DETECT(SC_DETECT), .GAN_OT_TRIP(GAN_OT_TRIP),
		.GAN_OT_CLEAR(GAN_OT_CLEAR), .DRV_OT_TRIP(DRV_OT_TRIP), .DRV_OT_CLEAR(DRV_OT_CLEAR),
		.Q1_CURRENT(Q1_CURRENT), .Q3_CURRENT(Q3_CURRENT), .TEMP_DEG(TEMP_DEG),
		.DRIVE_PIN_HIZ(DRIVE_PIN_HIZ), .DRIVE_PIN_AUX_5V(DRIVE_PIN_AUX_5V),
		.DRIVE_PIN_CODE(DRIVE_PIN_CODE), .GATE_ON(GATE_ON), .SLEW_SEL(SLEW_SEL),
		.FAULT_N(FAULT_N), .OVERCURRENT_FLAG_N_O(OC_O), .OVERCURRENT_FLAG_N_OE(OC_OE),
		.OVERCURRENT_FLAG_N_I(oc_pin), .TEMP_PWM(TEMP_PWM));

	supply_ctrl_model supply_ctrl_model_i (
		.clk(CLK), .temp_pwm(TEMP_PWM), .oc_o(OC_O), .oc_oe(OC_OE),
		.strap_gnd(strap_gnd), .oc_pin(oc_pin), .hi_cnt(hi_cnt), .per_cnt(per_cnt));

	// --------------------------------------------------------------
	// clock and watchdog
	// --------------------------------------------------------------
	initial begin
		forever #12.5 CLK = ~CLK;
	end
	// the whole run needs well under 20000 cycles
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			stop_test();
		end
	end

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge CLK);
	endtask
	// strap pins are held across release, then the mode strap is let go
	task automatic do_reset(input logic strap, input logic aux);
		RST_N = 0;
		strap_gnd = strap;
		DRIVE_PIN_AUX_5V = aux;
		tick(2);
		check(OC_OE, 0);
		RST_N = 1;
		tick(16);
		strap_gnd = 0;
	endtask
	task automatic set_fault(input int idx, input logic on);
		case (idx)
			1: UVLO = on;
			2: begin
				GAN_OT_TRIP = on;
				GAN_OT_CLEAR = !on;
			end
			3: DRIVE_PIN_HIZ = on;
			4: OC_DETECT = on;
			5: SC_DETECT = on;
			default: ;
		endcase
	endtask
	// {general, overcurrent} per fault index in two-output mode
	function automatic logic [1:0] exp_fault(input int idx);
		logic [1:0] tbl [6] = '{2'b11, 2'b01, 2'b01, 2'b01, 2'b10, 2'b00};
		return tbl[idx];
	endfunction
	function automatic logic [15:0] exp_hi(input int t);
		int v;
		v = (t * 10 - TEMP_OFS_X10) * P / TEMP_GAIN_X10;
		if (v < PWM_MIN_HIGH_CYC) v = PWM_MIN_HIGH_CYC;
		if (v > P - 1) v = P - 1;
		return 16'(v);
	endfunction
	// every fault except driver overtemperature applied with the switch commanded on, then cleared
	task automatic run_table(input logic single);
		logic [1:0] e;
		for (int i = 0; i < 6; i++) begin
			SWITCH_CMD = 1;
			set_fault(i, 1);
			tick(20);
			e = exp_fault(i);
			check(FAULT_N, single ? (i == 0) : e[1]);
			if (single) check(OC_OE, 0);
			else check(oc_pin, e[0]);
			if (i != 2) check(GATE_ON, i == 0);
			set_fault(i, 0);
			SWITCH_CMD = 0;
			tick(10);
			SWITCH_CMD = 1;
			tick(8);
			check(FAULT_N, 1);
			check(GATE_ON, 1);
		end
	endtask
	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask
	task automatic stop_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		do_reset(0, 0);
		// resistor code follows slowly; a short glitch is filtered out
		check(SLEW_SEL, SLEW_CODE_150);
		code = 16'(($random(seed) & 32'h7) + 1);
		DRIVE_PIN_CODE = code[3:0];
		tick(25);
		check(SLEW_SEL, code);
		DRIVE_PIN_CODE = 4'hF;
		tick(2);
		DRIVE_PIN_CODE = code[3:0];
		tick(2);
		check(SLEW_SEL, code);
		tick(23);
		check(SLEW_SEL, code);
		end_test("slew");
		run_table(0);
		end_test("two-output");
		// short circuit stays latched through a too-short command low
		SC_DETECT = 1;
		tick(4);
		SC_DETECT = 0;
		tick(10);
		SWITCH_CMD = 0;
		tick(2);
		SWITCH_CMD = 1;
		tick(8);
		check(GATE_ON, 0);
		check(oc_pin, 0);
		SWITCH_CMD = 0;
		tick(12);
		SWITCH_CMD = 1;
		tick(8);
		check(GATE_ON, 1);
		// overcurrent flag stays until the command goes low
		OC_DETECT = 1;
		tick(6);
		OC_DETECT = 0;
		tick(6);
		check(oc_pin, 0);
		SWITCH_CMD = 0;
		tick(6);
		check(oc_pin, 1);
		end_test("latch");
		// both sensors hot: pwm held high, fault until both cleared
		GAN_OT_TRIP = 1;
		GAN_OT_CLEAR = 0;
		DRV_OT_TRIP = 1;
		DRV_OT_CLEAR = 0;
		tick(10);
		hi = 0;
		repeat (150) begin
			@(negedge CLK);
			hi += TEMP_PWM;
		end
		check(16'(hi), 16'd150);
		// driver cooled, switch still hot: diode behaviour with fault held
		DRV_OT_TRIP = 0;
		DRV_OT_CLEAR = 1;
		Q3_CURRENT = 1;
		tick(8);
		check(FAULT_N, 0);
		check(GATE_ON, 1);
		Q3_CURRENT = 0;
		Q1_CURRENT = 1;
		tick(8);
		check(GATE_ON, 0);
		Q1_CURRENT = 0;
		// below the rising trip but not yet below the falling one: still held
		GAN_OT_TRIP = 0;
		tick(10);
		check(FAULT_N, 0);
		GAN_OT_CLEAR = 1;
		tick(10);
		check(FAULT_N, 1);
		end_test("overtemp");
		// corners first, then random temperatures in the target range
		for (int i = 0; i < 8; i++) begin
			TEMP_DEG = (i < 4) ? 8'(i * 50) : 8'(25 + ($random(seed) & 32'h7F) % 126);
			tick(3 * P);
			check(hi_cnt, exp_hi(int'(TEMP_DEG)));
			check(per_cnt, 16'(P));
		end
		end_test("pwm");
		do_reset(1, 0);
		run_table(1);
		end_test("single-output");
		// aux tie found once: fixed slew, pin no longer watched
		do_reset(0, 1);
		check(SLEW_SEL, SLEW_CODE_100);
		DRIVE_PIN_CODE = 4'h3;
		DRIVE_PIN_HIZ = 1;
		tick(25);
		check(SLEW_SEL, SLEW_CODE_100);
		check(FAULT_N, 1);
		end_test("aux-tie");
		stop_test();
	end
endmodule
